// file: inc/din3_pkg.sv
package din3_pkg;

    // Clock and timing
    localparam int  CLK_HZ          = 20_000_000;
    localparam real TELE_PERIOD_MS  = 6.5;
    localparam int  TELE_PERIOD_CYC = int'(TELE_PERIOD_MS * CLK_HZ / 1000.0);
    localparam real DLY_TICK_MS     = 1.0;
    localparam int  DLY_TICK_CYC    = int'(DLY_TICK_MS * CLK_HZ / 1000.0);
    localparam int  PER_W           = 18;
    localparam int  TICK_W          = 15;
    localparam int  NCH             = 3;

    // Register offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_LFD_EN = 8'h04;
    localparam logic [7:0] OFS_OFFDLY = 8'h08;
    localparam logic [7:0] OFS_INSTAT = 8'h0c;
    localparam logic [7:0] OFS_ISTAT  = 8'h10;
    localparam logic [7:0] OFS_IMASK  = 8'h14;

    // Field positions
    localparam int CTRL_WORD_BIT = 8;
    localparam int CTRL_EN_BIT   = 9;
    localparam int ST_BIT_OFS    = 0;
    localparam int LF_BIT_OFS    = 1;

    // Reset values
    localparam logic [7:0]  CODE_RST = 8'h10;
    localparam logic [2:0]  LFD_RST  = 3'h7;
    localparam logic [23:0] DLY_RST  = 24'h000000;
    localparam logic [3:0]  MASK_RST = 4'h0;

    // Configuration codes
    localparam logic [7:0] CODE_STD          = 8'h10;
    localparam logic [7:0] CODE_SMALL_IO_CFG = 8'h31;
    localparam logic [7:0] CODE_MED_IO_CFG   = 8'h33;
    localparam logic [7:0] CODE_LARGE_IO_CFG = 8'h37;

    // Event bits
    localparam int EV_W     = 4;
    localparam int EV_SENT  = 0;
    localparam int EV_FAULT = 1;
    localparam int EV_OVR   = 2;
    localparam int EV_OLEN  = 3;

    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SEND = 2'b10} tx_state_t;

    // Input telegram length in bytes, zero for an unknown code
    function automatic logic [3:0] in_len(input logic [7:0] code);
        case (code)
            CODE_STD:          in_len = 4'h1;
            CODE_SMALL_IO_CFG: in_len = 4'h2;
            CODE_MED_IO_CFG:   in_len = 4'h4;
            CODE_LARGE_IO_CFG: in_len = 4'h8;
            default:           in_len = 4'h0;
        endcase
    endfunction : in_len

    // Output telegram length in bytes
    function automatic logic [3:0] out_len(input logic [7:0] code);
        case (code)
            CODE_SMALL_IO_CFG: out_len = 4'h2;
            CODE_MED_IO_CFG:   out_len = 4'h4;
            CODE_LARGE_IO_CFG: out_len = 4'h8;
            default:           out_len = 4'h0;
        endcase
    endfunction : out_len

endpackage : din3_pkg

// file: inc/chan_if.sv
`timescale 1ns/1ps
interface chan_if;
    logic       level;
    logic       brk;
    logic       shrt;
    logic       lfd_en;
    logic       tick;
    logic [7:0] dly;
    logic       state;
    logic       fault;

    modport top  (output level, brk, shrt, lfd_en, tick, dly, input state, fault);
    modport chan (input level, brk, shrt, lfd_en, tick, dly, output state, fault);
endinterface : chan_if

// file: design/chan_cond.sv
`timescale 1ns/1ps
module chan_cond
    import din3_pkg::*;
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Channel link
    chan_if.chan      ch
);

    typedef struct packed {
        logic [7:0] hold_cnt;
        logic       state;
        logic       fault;
    } chan_st_t;

    chan_st_t st_r;
    chan_st_t st_nxt;

    // Off delay and line fault qualification
    always_comb
    begin
        st_nxt = st_r;
        if (ch.level)
        begin
            st_nxt.hold_cnt = ch.dly;
        end
        else if (ch.tick && st_r.hold_cnt != 8'h00)
        begin
            st_nxt.hold_cnt = st_r.hold_cnt - 8'h01;
        end
        st_nxt.state = ch.level | (st_r.hold_cnt != 8'h00);
        st_nxt.fault = ch.lfd_en & (ch.brk | ch.shrt);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign ch.state = st_r.state;
    assign ch.fault = st_r.fault;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_follow;
        ch.level |=> ch.state;
    endproperty
    property p_hold;
        !ch.level && st_r.hold_cnt != 8'h00 |=> ch.state;
    endproperty
    property p_lfd_off;
        !ch.lfd_en |=> !ch.fault;
    endproperty
    property p_detect;
        ch.lfd_en && (ch.brk || ch.shrt) |=> ch.fault;
    endproperty

    a_follow:  assert property (p_follow)  else $error("state not set by input");
    a_hold:    assert property (p_hold)    else $error("off delay dropped early");
    a_lfd_off: assert property (p_lfd_off) else $error("fault with detection off");
    a_detect:  assert property (p_detect)  else $error("line fault not flagged");

endmodule : chan_cond

// file: design/din3_telegram.sv
// Functional notes
// - Three independent input channels each give a status bit and a line fault bit.
// - Byte one holds status and fault of channels 1..3 in bit pairs 0/1, 2/3, 4/5, bits 6..7 empty.
// - Telegram length follows the code: 1 byte standard, 2, 4 or 8 bytes for the larger configurations.
// - Output telegram is 0, 2, 4 or 8 bytes by code and its contents are ignored.
// - The snapshot of inputs is sent to the communication unit every 6.5 ms.
// - Inputs up to 50 Hz are sampled without loss; visibility depends on the polling master.
// - Each input has a programmable off delay that stretches a falling input.
// - Lead breakage and short circuit are flagged in the channel's fault bit.
// - Line fault detection can be switched off per channel.
// - In word mode the high byte of each 16-bit word goes first, else bytes go in ascending order.
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module din3_telegram
    import din3_pkg::*;
#(
    parameter int PERIOD_CYC = TELE_PERIOD_CYC,
    parameter int MS_CYC     = DLY_TICK_CYC
)
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt
    output logic             irq,
    // Field input pins
    input  wire logic [2:0]  din,
    input  wire logic [2:0]  lead_brk,
    input  wire logic [2:0]  short_det,
    // Input telegram stream
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic      [7:0]  tx_data,
    output logic             tx_first,
    output logic             tx_last,
    // Output telegram stream
    input  wire logic        rx_valid,
    input  wire logic        rx_last
);

    typedef struct packed {
        logic [8:0]        sync1;
        logic [8:0]        sync2;
        logic [7:0]        code;
        logic              word;
        logic              en;
        logic [2:0]        lfd;
        logic [23:0]       dly;
        logic [EV_W-1:0]   stat;
        logic [EV_W-1:0]   mask;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        logic              irq;
        logic [PER_W-1:0]  per_cnt;
        logic              fire;
        logic [TICK_W-1:0] tick_cnt;
        logic              tick;
        tx_state_t         state;
        logic [7:0]        snap;
        logic              wsnap;
        logic [3:0]        len;
        logic [3:0]        idx;
        logic              tx_valid;
        logic [7:0]        tx_data;
        logic              tx_first;
        logic              tx_last;
        logic [3:0]        rx_cnt;
        logic [2:0]        prev_fault;
    } top_st_t;

    top_st_t    st_r;
    top_st_t    st_nxt;
    logic [2:0] ch_state;
    logic [2:0] ch_fault;
    logic [7:0] cur_byte;

    // Byte at send position; word mode swaps each byte pair
    function automatic logic [7:0] tele_byte(input logic [7:0] b1, input logic [3:0] idx,
                                             input logic word, input logic [3:0] len);
        logic [3:0] pos;
        pos = (word && len > 4'h1) ? (idx ^ 4'h1) : idx;
        tele_byte = (pos == 4'h0) ? b1 : 8'h00;
    endfunction : tele_byte

    // Per-channel conditioning
    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
        chan_if cif();
        assign cif.level  = st_r.sync2[i];
        assign cif.brk    = st_r.sync2[3+i];
        assign cif.shrt   = st_r.sync2[6+i];
        assign cif.lfd_en = st_r.lfd[i];
        assign cif.tick   = st_r.tick;
        assign cif.dly    = st_r.dly[8*i +: 8];
        assign ch_state[i] = cif.state;
        assign ch_fault[i] = cif.fault;
        chan_cond u_chan (
            .pclk    (pclk),
            .presetn (presetn),
            .ch      (cif.chan)
        );
    end

    // Byte one from channel pairs, top bits empty
    always_comb
    begin
        cur_byte = 8'h00;
        for (int i = 0; i < NCH; i++)
        begin
            cur_byte[2*i+ST_BIT_OFS] = ch_state[i];
            cur_byte[2*i+LF_BIT_OFS] = ch_fault[i];
        end
    end

    // Next state of the whole block
    always_comb
    begin
        logic [EV_W-1:0] ev;
        logic            done;
        logic            rd_stat;
        logic            hit;
        logic [31:0]     rdata;
        ev      = '0;
        done    = 1'b0;
        rd_stat = 1'b0;
        hit     = 1'b1;
        rdata   = 32'h00000000;
        st_nxt  = st_r;
        // Two-stage pin synchronisers
        st_nxt.sync1 = {short_det, lead_brk, din};
        st_nxt.sync2 = st_r.sync1;
        // Millisecond tick for the off delays
        st_nxt.tick = (st_r.tick_cnt == TICK_W'(MS_CYC - 1));
        st_nxt.tick_cnt = st_nxt.tick ? '0 : st_r.tick_cnt + 1'b1;
        // Telegram period
        st_nxt.fire = (st_r.per_cnt == PER_W'(PERIOD_CYC - 1));
        st_nxt.per_cnt = st_nxt.fire ? '0 : st_r.per_cnt + 1'b1;
        // Byte stream to the communication unit
        case (st_r.state)
            ST_IDLE:
            begin
                st_nxt.tx_valid = 1'b0;
            end
            ST_SEND:
            begin
                if (st_r.tx_valid && tx_ready)
                begin
                    if (st_r.tx_last)
                    begin
                        done            = 1'b1;
                        st_nxt.tx_valid = 1'b0;
                        st_nxt.tx_first = 1'b0;
                        st_nxt.tx_last  = 1'b0;
                        st_nxt.tx_data  = 8'h00;
                        st_nxt.state    = ST_IDLE;
                        ev[EV_SENT]     = 1'b1;
                    end
                    else
                    begin
                        st_nxt.idx      = st_r.idx + 4'h1;
                        st_nxt.tx_first = 1'b0;
                        st_nxt.tx_last  = (st_nxt.idx == st_r.len - 4'h1);
                        st_nxt.tx_data  = tele_byte(st_r.snap, st_nxt.idx, st_r.wsnap, st_r.len);
                    end
                end
            end
            default:
            begin
                st_nxt.state    = ST_IDLE;
                st_nxt.tx_valid = 1'b0;
            end
        endcase
        // Period start snapshots the inputs
        if (st_r.fire && st_r.en && in_len(st_r.code) != 4'h0)
        begin
            if (st_nxt.state == ST_SEND)
            begin
                ev[EV_OVR] = 1'b1;
            end
            else
            begin
                st_nxt.snap     = cur_byte;
                st_nxt.wsnap    = st_r.word;
                st_nxt.len      = in_len(st_r.code);
                st_nxt.idx      = 4'h0;
                st_nxt.tx_valid = 1'b1;
                st_nxt.tx_first = 1'b1;
                st_nxt.tx_last  = (st_nxt.len == 4'h1);
                st_nxt.tx_data  = tele_byte(cur_byte, 4'h0, st_r.word, st_nxt.len);
                st_nxt.state    = ST_SEND;
            end
        end
        // Output telegram length check, contents dropped
        if (rx_valid)
        begin
            if (rx_last)
            begin
                ev[EV_OLEN]   = (st_r.rx_cnt + 4'h1 != out_len(st_r.code));
                st_nxt.rx_cnt = 4'h0;
            end
            else if (st_r.rx_cnt != 4'hf)
            begin
                st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
            end
        end
        // Rising line faults
        ev[EV_FAULT] = |(ch_fault & ~st_r.prev_fault);
        st_nxt.prev_fault = ch_fault;
        // APB access phase, one wait state
        st_nxt.pready = 1'b0;
        if (psel && penable && !st_r.pready)
        begin
            case (paddr)
                OFS_CTRL:   rdata = {22'h0, st_r.en, st_r.word, st_r.code};
                OFS_LFD_EN: rdata = {29'h0, st_r.lfd};
                OFS_OFFDLY: rdata = {8'h00, st_r.dly};
                OFS_INSTAT: rdata = {24'h0, cur_byte};
                OFS_ISTAT:  rdata = {28'h0, st_r.stat};
                OFS_IMASK:  rdata = {28'h0, st_r.mask};
                default:    hit   = 1'b0;
            endcase
            st_nxt.pready  = 1'b1;
            st_nxt.pslverr = !hit;
            st_nxt.prdata  = pwrite ? 32'h00000000 : rdata;
            rd_stat        = !pwrite && paddr == OFS_ISTAT;
        end
        // Writes at the completing edge
        if (psel && penable && st_r.pready && pwrite)
        begin
            case (paddr)
                OFS_CTRL:
                begin
                    st_nxt.code = pwdata[7:0];
                    st_nxt.word = pwdata[CTRL_WORD_BIT];
                    st_nxt.en   = pwdata[CTRL_EN_BIT];
                end
                OFS_LFD_EN: st_nxt.lfd  = pwdata[2:0];
                OFS_OFFDLY: st_nxt.dly  = pwdata[23:0];
                OFS_IMASK:  st_nxt.mask = pwdata[EV_W-1:0];
                default:    st_nxt.code = st_r.code;
            endcase
        end
        // Sticky events, set wins over read clear
        st_nxt.stat = (rd_stat ? '0 : st_r.stat) | ev;
        st_nxt.irq  = |(st_nxt.stat & st_nxt.mask);
        if (done)
        begin
            st_nxt.idx = 4'h0;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r       <= '0;
            st_r.code  <= CODE_RST;
            st_r.lfd   <= LFD_RST;
            st_r.dly   <= DLY_RST;
            st_r.mask  <= MASK_RST;
            st_r.state <= ST_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign prdata   = st_r.prdata;
    assign pready   = st_r.pready;
    assign pslverr  = st_r.pslverr;
    assign irq      = st_r.irq;
    assign tx_valid = st_r.tx_valid;
    assign tx_data  = st_r.tx_data;
    assign tx_first = st_r.tx_first;
    assign tx_last  = st_r.tx_last;

    // Period check helper
    logic [PER_W-1:0] gap_q;
    logic             seen_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gap_q  <= '0;
            seen_q <= 1'b0;
        end
        else
        begin
            gap_q  <= st_r.fire ? '0 : gap_q + 1'b1;
            seen_q <= seen_q | st_r.fire;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_period;
        st_r.fire && seen_q |-> gap_q == PER_W'(PERIOD_CYC - 1);
    endproperty
    property p_top_empty;
        tx_valid |-> tx_data[7:6] == 2'b00;
    endproperty
    property p_empty_bytes;
        tx_valid && !tx_first && !st_r.wsnap |-> tx_data == 8'h00;
    endproperty
    property p_len;
        tx_valid && tx_last |-> st_r.idx == st_r.len - 4'h1;
    endproperty
    property p_len_snap;
        st_r.fire && st_r.en && st_r.state == ST_IDLE && in_len(st_r.code) != 4'h0 |=> st_r.len == in_len($past(st_r.code));
    endproperty
    property p_word_first;
        tx_valid && tx_first && st_r.wsnap && st_r.len > 4'h1 |-> tx_data == 8'h00;
    endproperty
    property p_byte_first;
        tx_valid && tx_first && !st_r.wsnap |-> tx_data == st_r.snap;
    endproperty
    property p_stall;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
    endproperty
    property p_apb_wait;
        psel && penable && !pready |=> pready;
    endproperty
    property p_olen;
        rx_valid && rx_last && st_r.rx_cnt + 4'h1 != out_len(st_r.code) |=> st_r.stat[EV_OLEN];
    endproperty

    a_period:      assert property (p_period)      else $error("telegram period wrong");
    a_top_empty:   assert property (p_top_empty)   else $error("empty bits not zero");
    a_empty_bytes: assert property (p_empty_bytes) else $error("empty byte not zero");
    a_len:         assert property (p_len)         else $error("telegram length wrong");
    a_len_snap:    assert property (p_len_snap)    else $error("snapshot length wrong");
    a_word_first:  assert property (p_word_first)  else $error("word order wrong");
    a_byte_first:  assert property (p_byte_first)  else $error("byte one not first");
    a_stall:       assert property (p_stall)       else $error("stream changed while stalled");
    a_apb_wait:    assert property (p_apb_wait)    else $error("apb answer late");
    a_olen:        assert property (p_olen)        else $error("output length error missed");

    c_word_send:  cover property (tx_valid && tx_ready && tx_last && st_r.wsnap);
    c_large_send: cover property (tx_valid && tx_ready && tx_last && st_r.len == 4'h8);
    c_overrun:    cover property (st_r.stat[EV_OVR]);
    c_irq:        cover property (irq);

endmodule : din3_telegram

// file: sim/com_unit_model.sv
`timescale 1ns/1ps
module com_unit_model
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Input telegram stream
    input  wire logic        tx_valid,
    output logic             tx_ready,
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_first,
    input  wire logic        tx_last,
    // Output telegram stream
    output logic             rx_valid,
    output logic             rx_last,
    // Bench control
    input  wire logic        stall,
    input  wire logic        rx_go,
    input  wire logic [3:0]  rx_n,
    // Last telegram seen
    output logic      [63:0] tele_bytes,
    output logic      [3:0]  tele_len,
    output logic      [7:0]  tele_cnt
);
    logic [63:0] buf_r;
    logic [63:0] buf_nxt;
    logic [3:0]  pos_r;
    logic [3:0]  pos_nxt;
    logic        ph_r;
    logic [3:0]  left_r;

    // Half rate acceptance while stalling
    assign tx_ready = presetn & (~stall | ph_r);
    // Byte collection, restarted by the first byte
    assign buf_nxt = (tx_first ? 64'h0 : buf_r) | (64'(tx_data) << (8 * (tx_first ? 4'h0 : pos_r)));
    assign pos_nxt = (tx_first ? 4'h0 : pos_r) + 4'h1;

    // Capture telegrams and send output bytes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            buf_r      <= 64'h0;
            pos_r      <= 4'h0;
            ph_r       <= 1'b0;
            left_r     <= 4'h0;
            rx_valid   <= 1'b0;
            rx_last    <= 1'b0;
            tele_bytes <= 64'h0;
            tele_len   <= 4'h0;
            tele_cnt   <= 8'h0;
        end
        else
        begin
            ph_r     <= ~ph_r;
            rx_valid <= 1'b0;
            rx_last  <= 1'b0;
            if (tx_valid && tx_ready)
            begin
                buf_r <= buf_nxt;
                pos_r <= pos_nxt;
                if (tx_last)
                begin
                    tele_bytes <= buf_nxt;
                    tele_len   <= pos_nxt;
                    tele_cnt   <= tele_cnt + 8'h1;
                end
            end
            // Output bytes sized as the bench configures
            if (rx_go)
                left_r <= rx_n;
            else if (left_r != 4'h0 && !rx_valid)
            begin
                rx_valid <= 1'b1;
                rx_last  <= (left_r == 4'h1);
                left_r   <= left_r - 4'h1;
            end
        end
    end
endmodule : com_unit_model

// file: sim/three_channel_input_telegram_tb.sv
`timescale 1ns/1ps
module three_channel_input_telegram_tb;
    import din3_pkg::*;
    localparam int PER = 200;
    localparam int MSC = 4;
    // Stimulus and observed signals
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, irq;
    logic [2:0]  din = 3'h0;
    logic [2:0]  lead_brk = 3'h0;
    logic [2:0]  short_det = 3'h0;
    logic        tx_valid, tx_ready, tx_first, tx_last, rx_valid, rx_last;
    logic [7:0]  tx_data;
    logic        stall = 1'b0;
    logic        rx_go = 1'b0;
    logic [3:0]  rx_n = 4'h0;
    logic [63:0] tele_bytes;
    logic [3:0]  tele_len;
    logic [7:0]  tele_cnt;
    int          n_mismatch = 0;
    int          compares = 0;
    int          cyc = 0;

    din3_telegram #(.PERIOD_CYC(PER), .MS_CYC(MSC)) i_din3_telegram (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .din(din), .lead_brk(lead_brk), .short_det(short_det),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_first(tx_first), .tx_last(tx_last),
        .rx_valid(rx_valid), .rx_last(rx_last));
    com_unit_model i_com_unit_model (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .tx_first(tx_first), .tx_last(tx_last), .rx_valid(rx_valid), .rx_last(rx_last),
        .stall(stall), .rx_go(rx_go), .rx_n(rx_n), .tele_bytes(tele_bytes), .tele_len(tele_len),
        .tele_cnt(tele_cnt));

    always #25 pclk = ~pclk;

    // Hang guard
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_mismatch++;
            give_verdict;
        end
    end

    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, rd, er);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk, input string what);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 32'h0, rd, er);
        chk(exp, rd & msk, what);
    endtask : rdc

    // Wait for n telegrams to arrive
    task automatic tele(input int n);
        logic [7:0] c;
        repeat (n)
        begin
            c = tele_cnt;
            while (tele_cnt == c)
            begin
                @(posedge pclk);
            end
        end
    endtask : tele

    function automatic logic [7:0] b1(input logic [2:0] s, input logic [2:0] f);
        b1 = {2'b00, f[2], s[2], f[1], s[1], f[0], s[0]};
    endfunction : b1

    task automatic t_regs;
        logic [31:0] rd;
        logic        er;
        rdc(OFS_CTRL, 32'h10, 32'hffffffff, "ctrl reset");
        rdc(OFS_LFD_EN, 32'h7, 32'hffffffff, "lfd reset");
        rdc(OFS_OFFDLY, 32'h0, 32'hffffffff, "offdly reset");
        rdc(OFS_IMASK, 32'h0, 32'hffffffff, "imask reset");
        rdc(OFS_ISTAT, 32'h0, 32'hffffffff, "istat reset");
        apb(1'b0, 8'h18, 32'h0, rd, er);
        chk(32'h1, 32'(er), "unmapped error");
        chk(32'h0, rd, "unmapped data");
        $display("t_regs done");
    endtask : t_regs

    task automatic t_layout;
        din       <= 3'b101;
        lead_brk  <= 3'b011;
        short_det <= 3'b100;
        wr(OFS_CTRL, 32'h210);
        tele(2);
        chk(32'h1, 32'(tele_len), "std length");
        chk(32'(b1(3'b101, 3'b111)), 32'(tele_bytes[7:0]), "byte one");
        rdc(OFS_INSTAT, 32'(b1(3'b101, 3'b111)), 32'hffffffff, "instat");
        rdc(OFS_ISTAT, 32'h3, 32'h3, "events");
        wr(OFS_LFD_EN, 32'h1);
        tele(2);
        chk(32'(b1(3'b101, 3'b001)), 32'(tele_bytes[7:0]), "lfd off");
        $display("t_layout done");
    endtask : t_layout

    task automatic t_lengths;
        logic [7:0] codes [3] = '{CODE_SMALL_IO_CFG, CODE_MED_IO_CFG, CODE_LARGE_IO_CFG};
        logic [3:0] lens [3] = '{4'h2, 4'h4, 4'h8};
        din       <= 3'b011;
        lead_brk  <= 3'b000;
        short_det <= 3'b000;
        for (int i = 0; i < 3; i++)
        begin
            stall <= (i != 0);
            wr(OFS_CTRL, 32'h200 | 32'(codes[i]));
            tele(2);
            chk(32'(lens[i]), 32'(tele_len), "length");
            chk(32'(b1(3'b011, 3'b000)), tele_bytes[31:0], "low bytes");
            chk(32'h0, tele_bytes[63:32], "high bytes");
        end
        stall <= 1'b0;
        $display("t_lengths done");
    endtask : t_lengths

    task automatic t_word;
        din <= 3'b010;
        wr(OFS_CTRL, 32'h300 | 32'(CODE_MED_IO_CFG));
        tele(2);
        chk(32'h4, 32'(tele_len), "word length");
        chk(32'h00000400, tele_bytes[31:0], "word order");
        wr(OFS_CTRL, 32'h300 | 32'(CODE_STD));
        tele(2);
        chk(32'h00000004, tele_bytes[31:0], "word std");
        $display("t_word done");
    endtask : t_word

    task automatic t_period;
        realtime t0;
        tele(1);
        t0 = $realtime;
        tele(1);
        chk(32'(PER), 32'(int'(($realtime - t0) / 50.0)), "period");
        $display("t_period done");
    endtask : t_period

    task automatic t_offdly;
        wr(OFS_CTRL, 32'h210);
        din <= 3'b000;
        wr(OFS_OFFDLY, 32'h00000500);
        @(posedge pclk);
        din <= 3'b011;
        repeat (10) @(posedge pclk);
        din <= 3'b000;
        repeat (6) @(posedge pclk);
        rdc(OFS_INSTAT, 32'h4, 32'h3f, "stretch");
        repeat (30) @(posedge pclk);
        rdc(OFS_INSTAT, 32'h0, 32'h3f, "released");
        $display("t_offdly done");
    endtask : t_offdly

    task automatic t_rx;
        logic [7:0] code [4] = '{CODE_MED_IO_CFG, CODE_MED_IO_CFG, CODE_STD, CODE_LARGE_IO_CFG};
        logic [3:0] n [4] = '{4'h3, 4'h4, 4'h2, 4'h8};
        logic       msk [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
        logic       bad [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_CTRL, 32'h200 | 32'(code[i]));
            wr(OFS_IMASK, {28'h0, msk[i], 3'b000});
            rdc(OFS_ISTAT, 32'h0, 32'h8, "istat clean");
            rx_n  <= n[i];
            rx_go <= 1'b1;
            @(posedge pclk);
            rx_go <= 1'b0;
            repeat (24) @(posedge pclk);
            chk(32'(bad[i] & msk[i]), 32'(irq), "irq");
            rdc(OFS_ISTAT, {28'h0, bad[i], 3'b000}, 32'h8, "length error");
            repeat (2) @(posedge pclk);
            chk(32'h0, 32'(irq), "irq cleared");
        end
        $display("t_rx done");
    endtask : t_rx

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_layout;
        t_lengths;
        t_word;
        t_period;
        t_offdly;
        t_rx;
        give_verdict;
    end
endmodule : three_channel_input_telegram_tb
